//--- bench/regulator_slot_control_tb.sv
// Self-checking bench for the regulator slot control block.
`include "rsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module regulator_slot_control_tb;
  typedef struct {logic rd; logic [31:0] d; logic e;} rsc_note_s;
  localparam logic [19:0] A9S  = 20'(4 * `RSC_IDX_R9_SLEEP);
  localparam logic [19:0] A10G = 20'(4 * `RSC_IDX_R10_GENERAL);
  localparam logic [19:0] A10O = 20'(4 * `RSC_IDX_R10_ON);
  localparam logic [19:0] A10S = 20'(4 * `RSC_IDX_R10_SLEEP);
  localparam logic [19:0] AST  = 20'(4 * `RSC_IDX_STATUS);
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic        seq_slot_strobe, seq_powerup, reg9_hw_assigned;
  logic [2:0]  seq_slot_num;
  logic        hw_enable1_pin, hw_enable2_pin, reg10_uv_pin;
  logic        reg9_sleep_active_q, reg9_disable_q, reg9_lowpower_q;
  logic        reg10_enable_q, reg10_lowpower_q, reg10_discharge_q;
  logic        reg10_switch_q, uv_irq_q, sys_reset_req_q;
  logic [4:0]  reg9_vcode_q, reg10_vcode_q;
  logic [11:0] reg9_millivolts_q, reg10_millivolts_q;
  int          errors, tests_run, seed, i, n, s;
  rsc_note_s   notes[$];
  rsc_note_s   note;

  rsc_top dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .seq_slot_strobe, .seq_slot_num,
    .seq_powerup, .reg9_hw_assigned, .hw_enable1_pin, .hw_enable2_pin,
    .reg10_uv_pin, .reg9_sleep_active_q, .reg9_disable_q, .reg9_vcode_q,
    .reg9_lowpower_q, .reg9_millivolts_q, .reg10_enable_q, .reg10_vcode_q,
    .reg10_lowpower_q, .reg10_millivolts_q, .reg10_discharge_q,
    .reg10_switch_q, .uv_irq_q, .sys_reset_req_q);

  // 10 MHz clock
  initial
  begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] mv(input logic [4:0] c);
    return (c <= 5'h0c) ? 1000 + 50 * c : 1700 + 100 * (c - 13);
  endfunction : mv

  task chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // One bus transfer; the expected answer is queued for the monitor
  task apb(input logic w, input logic [19:0] a, input logic [31:0] d,
           input logic [31:0] x, input logic e);
    notes.push_back('{!w, x, e});
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Sequencer strobe, then time for the outputs to follow
  task slot(input logic pu, input logic [2:0] sn);
    @(posedge ref_clk);
    seq_slot_strobe <= 1;
    seq_powerup <= pu;
    seq_slot_num <= sn;
    @(posedge ref_clk);
    seq_slot_strobe <= 0;
    repeat (3) @(posedge ref_clk);
  endtask : slot

  // Answers are matched against the oldest queued note
  always @(posedge ref_clk)
    if (pready === 1'b1)
    begin
      note = notes.pop_front();
      chk("pslverr", note.e, pslverr);
      if (note.rd) chk("prdata", note.d, prdata);
    end

  // Watchdog, far beyond the expected run of under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    report_and_stop;
  end

  initial
  begin
    seed = 91139;
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {seq_slot_strobe, seq_slot_num, seq_powerup} = '0;
    {reg9_hw_assigned, hw_enable1_pin, hw_enable2_pin, reg10_uv_pin} = '0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1;
    @(posedge ref_clk);
    chk("r9 lowpower", 1, reg9_lowpower_q);
    chk("r10 lowpower", 0, reg10_lowpower_q);
    chk("r10 discharge", 1, reg10_discharge_q);
    apb(0, A9S, 0, 32'h0100, 0);
    apb(0, A10G, 0, 32'h0200, 0);
    apb(0, A10O, 0, 0, 0);
    apb(1, 20'h10300, 32'h1234, 0, 1);
    apb(0, 20'h10300, 0, 0, 1);
    apb(1, AST, 32'h00ff, 0, 1);
    v = $random(seed) & 32'h5fc0;
    apb(1, A10G, v, 0, 0);
    apb(0, A10G, 0, v, 0);
    apb(1, A10G, 32'h02c0, 0, 0);
    repeat (3) @(posedge ref_clk);
    chk("r10 discharge", 0, reg10_discharge_q);
    chk("r10 switch", 1, reg10_switch_q);
    // Every sleep voltage code
    for (i = 0; i < 32; i++)
    begin
      apb(1, A9S, {27'h0, i[4:0]}, 0, 0);
      repeat (2) @(posedge ref_clk);
      chk("r9 mv", mv(i[4:0]), reg9_millivolts_q);
    end
    chk("r9 lowpower", 0, reg9_lowpower_q);
    // On slots one to five, then sleep at timeslot five, then off
    apb(1, A10G, 32'h0200, 0, 0);
    apb(1, A10S, 32'h001f, 0, 0);
    for (i = 1; i <= 5; i++)
    begin
      v = $random(seed) & 32'h011f;
      apb(1, A10O, {16'h0, i[2:0], 13'h0} | v, 0, 0);
      slot(1, 3'(i % 5 + 1));
      chk("r10 enable", 0, reg10_enable_q);
      slot(1, i[2:0]);
      chk("r10 enable", 1, reg10_enable_q);
      chk("r10 lowpower", v[8], reg10_lowpower_q);
      chk("r10 mv", mv(v[4:0]), reg10_millivolts_q);
      slot(0, 3'h5);
      chk("r10 sleep mv", 3500, reg10_millivolts_q);
      chk("r10 sleep lp", 1, reg10_lowpower_q);
      apb(1, A10O, 0, 0, 0);
      repeat (3) @(posedge ref_clk);
      chk("r10 off", 0, reg10_enable_q);
      chk("r10 discharge", 1, reg10_discharge_q);
    end
    // Ninth regulator sleep slot codes, without and with a hw enable input
    for (i = 0; i < 16; i++)
    begin
      reg9_hw_assigned <= i[3];
      apb(1, A9S, {16'h0, i[2:0], 13'h0}, 0, 0);
      slot(1, 3'h1);
      n = i % 8;
      s = (n == 0) ? 5 : (n == 6) ? 3 : (n == 7) ? 1 : 6 - n;
      slot(0, 3'(s % 5 + 1));
      chk("r9 early", 0, reg9_sleep_active_q | reg9_disable_q);
      slot(0, 3'(s));
      chk("r9 slp", n==0||n>5||i[3], reg9_sleep_active_q);
      chk("r9 dis", n>0&&n<6&&!i[3], reg9_disable_q);
    end
    // Undervoltage with each permitted action
    for (i = 0; i < 3; i++)
    begin
      apb(1, A10O, 32'h2000, 0, 0);
      slot(1, 3'h1);
      apb(1, A10G, {16'h0, i[1:0], 14'h0200}, 0, 0);
      reg10_uv_pin <= 1;
      n = 0;
      while (uv_irq_q !== 1'b1 && n < 12)
      begin
        @(posedge ref_clk);
        n++;
      end
      chk("uv irq", 1, uv_irq_q);
      chk("sys reset", (i == 2), sys_reset_req_q);
      repeat (3) @(posedge ref_clk);
      chk("uv enable", (i != 1), reg10_enable_q);
      reg10_uv_pin <= 0;
      repeat (8) @(posedge ref_clk);
    end
    // Enable from hw input 1, which also takes hw control of volts and mode
    apb(1, A10G, 32'h0c00, 0, 0);
    apb(1, A10O, 32'hc003, 0, 0);
    hw_enable1_pin <= 1;
    repeat (8) @(posedge ref_clk);
    chk("hw enable", 1, reg10_enable_q);
    chk("hw mv", 3500, reg10_millivolts_q);
    chk("hw lp", 1, reg10_lowpower_q);
    apb(1, A10G, 32'h0d00, 0, 0);
    repeat (3) @(posedge ref_clk);
    chk("hw off", 0, reg10_enable_q);
    report_and_stop;
  end
endmodule : regulator_slot_control_tb

bind rsc_top rsc_checker u_chk (.ref_clk, .nrst, .psel, .penable, .prdata,
  .pready, .pslverr, .reg10_uv_pin, .reg9_vcode_q, .reg9_millivolts_q,
  .reg10_enable_q, .reg10_vcode_q, .reg10_millivolts_q, .reg10_discharge_q,
  .uv_irq_q, .sys_reset_req_q);
`default_nettype wire

//--- bench/rsc_checker.sv
// Port checker for the regulator slot control block.
`include "rsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rsc_checker
  import rsc_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [`RSC_DATA_W-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   reg10_uv_pin,
  input wire logic [4:0]             reg9_vcode_q,
  input wire logic [`RSC_MV_W-1:0]   reg9_millivolts_q,
  input wire logic                   reg10_enable_q,
  input wire logic [4:0]             reg10_vcode_q,
  input wire logic [`RSC_MV_W-1:0]   reg10_millivolts_q,
  input wire logic                   reg10_discharge_q,
  input wire logic                   uv_irq_q,
  input wire logic                   sys_reset_req_q
);
  // Millivolts of a code: fine steps up to the knee, coarse after it
  function automatic logic [11:0] mv(input logic [4:0] c);
    mv = (c <= 5'h0c) ? 12'h3e8 + 12'h032 * c
                      : 12'h6a4 + 12'h064 * (c - 5'h0d);
  endfunction : mv

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Bus answer is one access cycle, data only with the answer
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside the answer");
  slverr_qual_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Undervoltage reporting
  irq_pulse_a: assert property (uv_irq_q |=> !uv_irq_q)
    else $error("interrupt longer than one cycle");
  uv_irq_a: assert property (
    $rose(reg10_uv_pin) |-> ##[2:6] uv_irq_q)
    else $error("no interrupt after undervoltage");
  sysrst_irq_a: assert property (sys_reset_req_q |-> uv_irq_q)
    else $error("reset request without interrupt");
  // Discharge only while the output is off
  discharge_on_a: assert property (
    reg10_enable_q |-> !reg10_discharge_q)
    else $error("discharge while enabled");
  // Code to millivolt mapping, once the code has settled
  vmap_nine_a: assert property (
    $stable(reg9_vcode_q) ##1 $stable(reg9_vcode_q)
    |-> reg9_millivolts_q == mv(reg9_vcode_q))
    else $error("ninth regulator millivolts wrong");
  vmap_ten_a: assert property (
    $stable(reg10_vcode_q) ##1 $stable(reg10_vcode_q)
    |-> reg10_millivolts_q == mv(reg10_vcode_q))
    else $error("tenth regulator millivolts wrong");
endmodule : rsc_checker
`default_nettype wire

//--- rtl/rsc_params.svh
// Constants for the regulator slot control block: offsets, fields, resets.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// Register indices; byte address is four times the index
`define RSC_IDX_R9_SLEEP      16'h4082
`define RSC_IDX_R10_GENERAL   16'h4083
`define RSC_IDX_R10_ON        16'h4084
`define RSC_IDX_R10_SLEEP     16'h4085
`define RSC_IDX_STATUS        16'h4090
`define RSC_ADDR_W            20
`define RSC_DATA_W            32
`define RSC_REG_W             16

// Field positions
`define RSC_SLOT_HI           15
`define RSC_SLOT_LO           13
`define RSC_OPMODE_BIT        8
`define RSC_VCODE_HI          4
`define RSC_VCODE_LO          0
`define RSC_FAULT_HI          15
`define RSC_FAULT_LO          14
`define RSC_HWSRC_HI          12
`define RSC_HWSRC_LO          11
`define RSC_HWVSEL_BIT        10
`define RSC_HWMODE_HI         9
`define RSC_HWMODE_LO         8
`define RSC_FLOAT_BIT         7
`define RSC_SWITCH_BIT        6

// Reset values
`define RSC_RST_SLOT          3'h0
`define RSC_RST_SLEEP_MODE    1'b1
`define RSC_RST_ON_MODE       1'b0
`define RSC_RST_VCODE         5'h00
`define RSC_RST_FAULT         2'h0
`define RSC_RST_HWSRC         2'h0
`define RSC_RST_HWVSEL        1'b0
`define RSC_RST_HWMODE        2'h2
`define RSC_RST_BIT           1'b0

// Slot codes
`define RSC_SLOT_NONE         3'h0
`define RSC_SLOT_FIRST        3'h1
`define RSC_SLOT_LAST         3'h5
`define RSC_SLOT_TS1          3'h1
`define RSC_SLOT_TS3          3'h3
`define RSC_SLOT_TS5          3'h5
`define RSC_SLOT_CODE_HW1     3'h6
`define RSC_SLOT_CODE_HW2     3'h7
`define RSC_SLOT_MIRROR       3'h6
`define RSC_R10_SLEEP_SLOT    3'h5

// Fault actions, hardware source and hardware mode codes
`define RSC_FAULT_IGNORE      2'h0
`define RSC_FAULT_REG_OFF     2'h1
`define RSC_FAULT_SYS_RESET   2'h2
`define RSC_HWSRC_OFF         2'h0
`define RSC_HWSRC_IN1         2'h1
`define RSC_HWSRC_IN2         2'h2
`define RSC_HWSRC_ANY         2'h3
`define RSC_HWMODE_LP0        2'h0
`define RSC_HWMODE_OFF        2'h1
`define RSC_HWMODE_LP2        2'h2
`define RSC_HWMODE_FOLLOW     2'h3

// Voltage code mapping in millivolts
`define RSC_MV_W              12
`define RSC_VCODE_KNEE        5'h0c
`define RSC_VCODE_UPPER0      5'h0d
`define RSC_MV_BASE_LO        12'h3e8
`define RSC_MV_STEP_LO        12'h032
`define RSC_MV_BASE_HI        12'h6a4
`define RSC_MV_STEP_HI        12'h064

`endif

//--- rtl/rsc_pkg.sv
// Types for the regulator slot control block.
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_R10_OFF   = 2'b00,
    RSC_R10_ON    = 2'b01,
    RSC_R10_SLEEP = 2'b10
  } rsc_r10_state_e;
endpackage : rsc_pkg

//--- rtl/rsc_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module rsc_sync (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  output var  logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage feeds only the second; change counts once stages 2 and 3 agree
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
      end
    end
  end
endmodule : rsc_sync
`default_nettype wire

//--- rtl/rsc_top.sv
// Sleep and on-state control of the ninth and tenth linear regulators.
//
// How it works
// RULE1: reg9 sleep slot code picks apply-sleep or disable timeslot
// RULE2: with hardware enable, codes 001-101 pick the sleep-entry timeslot
// RULE3: reg9 sleep mode bit 8, 1 low power, resets to 1
// RULE4: voltage codes map 1.00-1.60V by 50mV, then 1.70-3.50V by 100mV
// RULE5: undervoltage action ignore, regulator off, or device reset
// RULE6: undervoltage always raises an interrupt pulse
// RULE7: hardware source off, input 1, input 2, or either, resets 00
// RULE8: under hardware control voltage bit picks on or sleep code
// RULE9: hardware mode low power, off, low power, or follow on mode
// RULE10: float bit 7 stops discharge; bit 6 selects switch mode
// RULE11: reg10 on slot never, timeslot one to five, or hw enable input
// RULE12: reg10 on mode bit 8, 1 low power, resets to 0
// RULE13: reg10 on voltage code bits 4:0 uses the same mapping
// RULE14: on settings while on, sleep settings from the sleep timeslot
//
// The implementer's own choice: register access over APB.
`include "rsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RSC_ADDR_W-1:0] paddr,
  input  wire logic [`RSC_DATA_W-1:0] pwdata,
  output var  logic [`RSC_DATA_W-1:0] prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  input  wire logic                   seq_slot_strobe,
  input  wire logic [2:0]             seq_slot_num,
  input  wire logic                   seq_powerup,
  input  wire logic                   reg9_hw_assigned,
  input  wire logic                   hw_enable1_pin,
  input  wire logic                   hw_enable2_pin,
  input  wire logic                   reg10_uv_pin,
  output var  logic                   reg9_sleep_active_q,
  output var  logic                   reg9_disable_q,
  output var  logic [4:0]             reg9_vcode_q,
  output var  logic                   reg9_lowpower_q,
  output var  logic [`RSC_MV_W-1:0]   reg9_millivolts_q,
  output var  logic                   reg10_enable_q,
  output var  logic [4:0]             reg10_vcode_q,
  output var  logic                   reg10_lowpower_q,
  output var  logic [`RSC_MV_W-1:0]   reg10_millivolts_q,
  output var  logic                   reg10_discharge_q,
  output var  logic                   reg10_switch_q,
  output var  logic                   uv_irq_q,
  output var  logic                   sys_reset_req_q
);

  // Software fields
  logic [2:0] reg9_sleep_slot_q;
  logic       reg9_sleep_opmode_q;
  logic [4:0] reg9_sleep_voltage_code_q;
  logic [1:0] reg10_fault_action_q;
  logic [1:0] reg10_hw_ctrl_source_q;
  logic       reg10_hw_ctrl_voltage_pick_q;
  logic [1:0] reg10_hw_ctrl_opmode_q;
  logic       reg10_output_float_q;
  logic       reg10_switch_select_q;
  logic [2:0] reg10_on_slot_q;
  logic       reg10_on_opmode_q;
  logic [4:0] reg10_on_voltage_code_q;
  logic [4:0] reg10_sleep_voltage_code_q;

  // Block state
  rsc_r10_state_e r10_state_q;
  rsc_r10_state_e r10_state_d;
  logic           fault_off_q;
  logic           fault_off_d;
  logic           uv_prev_q;
  logic [2:0]     sync_lvl;
  logic           hw_active;

  // Pin inputs cross into ref_clk through one synchroniser each
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      rsc_sync u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pin_in  ((gi == 0) ? hw_enable1_pin :
                  (gi == 1) ? hw_enable2_pin : reg10_uv_pin),
        .level_q (sync_lvl[gi])
      );
    end
  endgenerate

  wire hw1 = sync_lvl[0];
  wire hw2 = sync_lvl[1];
  wire uv  = sync_lvl[2];

  // APB decode; byte address is index shifted by two
  wire sel_r9s  = paddr == {2'b00, `RSC_IDX_R9_SLEEP, 2'b00};
  wire sel_r10g = paddr == {2'b00, `RSC_IDX_R10_GENERAL, 2'b00};
  wire sel_r10o = paddr == {2'b00, `RSC_IDX_R10_ON, 2'b00};
  wire sel_r10s = paddr == {2'b00, `RSC_IDX_R10_SLEEP, 2'b00};
  wire sel_stat = paddr == {2'b00, `RSC_IDX_STATUS, 2'b00};
  wire sel_any  = sel_r9s | sel_r10g | sel_r10o | sel_r10s | sel_stat;
  wire setup    = psel & ~penable;
  wire commit   = psel & penable & pready;
  // Status is read-only, so a write to it is an error as well
  wire bad      = ~sel_any | (pwrite & sel_stat);
  wire wr_ok    = commit & pwrite & ~bad;
  wire wr_r9s   = wr_ok & sel_r9s;
  wire wr_r10g  = wr_ok & sel_r10g;
  wire wr_r10o  = wr_ok & sel_r10o;
  wire wr_r10s  = wr_ok & sel_r10s;

  // Read images; reserved bits read as zero
  wire [`RSC_REG_W-1:0] rd_r9s = {reg9_sleep_slot_q, 4'h0,
    reg9_sleep_opmode_q, 3'h0, reg9_sleep_voltage_code_q};
  wire [`RSC_REG_W-1:0] rd_r10g = {reg10_fault_action_q, 1'b0,
    reg10_hw_ctrl_source_q, reg10_hw_ctrl_voltage_pick_q,
    reg10_hw_ctrl_opmode_q, reg10_output_float_q,
    reg10_switch_select_q, 6'h00};
  wire [`RSC_REG_W-1:0] rd_r10o = {reg10_on_slot_q, 4'h0,
    reg10_on_opmode_q, 3'h0, reg10_on_voltage_code_q};
  wire [`RSC_REG_W-1:0] rd_r10s = {11'h000, reg10_sleep_voltage_code_q};
  wire [`RSC_REG_W-1:0] rd_stat = {8'h00, uv, hw_active, reg9_disable_q,
    reg9_sleep_active_q, fault_off_q, (r10_state_q == RSC_R10_SLEEP),
    (r10_state_q == RSC_R10_ON), reg10_enable_q};
  wire [`RSC_REG_W-1:0] rd_sel =
    sel_r9s  ? rd_r9s  :
    sel_r10g ? rd_r10g :
    sel_r10o ? rd_r10o :
    sel_r10s ? rd_r10s :
    sel_stat ? rd_stat : 16'h0000;

  // Answer registered in the setup cycle so the access phase has no wait
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & bad;
      prdata  <= (setup & ~pwrite) ? {16'h0000, rd_sel} : 32'h0000_0000;
    end
  end

  // Software writes to the three mapped control words and the sleep code
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg9_sleep_slot_q            <= `RSC_RST_SLOT;
      reg9_sleep_opmode_q          <= `RSC_RST_SLEEP_MODE; // [RULE3]
      reg9_sleep_voltage_code_q    <= `RSC_RST_VCODE;      // [RULE4]
      reg10_fault_action_q         <= `RSC_RST_FAULT;
      reg10_hw_ctrl_source_q       <= `RSC_RST_HWSRC;      // [RULE7]
      reg10_hw_ctrl_voltage_pick_q <= `RSC_RST_HWVSEL;
      reg10_hw_ctrl_opmode_q       <= `RSC_RST_HWMODE;     // [RULE9]
      reg10_output_float_q         <= `RSC_RST_BIT;
      reg10_switch_select_q        <= `RSC_RST_BIT;
      reg10_on_slot_q              <= `RSC_RST_SLOT;
      reg10_on_opmode_q            <= `RSC_RST_ON_MODE;    // [RULE12]
      reg10_on_voltage_code_q      <= `RSC_RST_VCODE;
      reg10_sleep_voltage_code_q   <= `RSC_RST_VCODE;
    end
    else
    begin
      if (wr_r9s)
      begin
        reg9_sleep_slot_q         <= pwdata[`RSC_SLOT_HI:`RSC_SLOT_LO];
        reg9_sleep_opmode_q       <= pwdata[`RSC_OPMODE_BIT];
        reg9_sleep_voltage_code_q <= pwdata[`RSC_VCODE_HI:`RSC_VCODE_LO];
      end
      if (wr_r10g)
      begin
        reg10_fault_action_q   <= pwdata[`RSC_FAULT_HI:`RSC_FAULT_LO];
        reg10_hw_ctrl_source_q <= pwdata[`RSC_HWSRC_HI:`RSC_HWSRC_LO];
        reg10_hw_ctrl_voltage_pick_q <= pwdata[`RSC_HWVSEL_BIT];
        reg10_hw_ctrl_opmode_q <= pwdata[`RSC_HWMODE_HI:`RSC_HWMODE_LO];
        reg10_output_float_q   <= pwdata[`RSC_FLOAT_BIT];
        reg10_switch_select_q  <= pwdata[`RSC_SWITCH_BIT];
      end
      if (wr_r10o)
      begin
        reg10_on_slot_q         <= pwdata[`RSC_SLOT_HI:`RSC_SLOT_LO];
        reg10_on_opmode_q       <= pwdata[`RSC_OPMODE_BIT];
        reg10_on_voltage_code_q <= pwdata[`RSC_VCODE_HI:`RSC_VCODE_LO];
      end
      if (wr_r10s)
      begin
        reg10_sleep_voltage_code_q <= pwdata[`RSC_VCODE_HI:`RSC_VCODE_LO];
      end
    end
  end

  // Code to millivolts, two linear segments meeting at the knee
  function automatic logic [`RSC_MV_W-1:0] vcode_mv(input logic [4:0] c);
    logic [4:0] up;
    up = c - `RSC_VCODE_UPPER0;
    if (c <= `RSC_VCODE_KNEE)
      vcode_mv = `RSC_MV_BASE_LO + `RSC_MV_STEP_LO * {7'h00, c}; // [RULE4]
    else
      vcode_mv = `RSC_MV_BASE_HI + `RSC_MV_STEP_HI * {7'h00, up}; // [RULE4]
  endfunction : vcode_mv

  // Ninth regulator sleep timeslot decode
  wire r9_code_mid = (reg9_sleep_slot_q >= `RSC_SLOT_FIRST) &&
                     (reg9_sleep_slot_q <= `RSC_SLOT_LAST);
  // Codes 001-101 count timeslots down from five
  wire [2:0] r9_mid_slot = `RSC_SLOT_MIRROR - reg9_sleep_slot_q;
  wire [2:0] r9_target =
    (reg9_sleep_slot_q == `RSC_SLOT_NONE)     ? `RSC_SLOT_TS5 :
    (reg9_sleep_slot_q == `RSC_SLOT_CODE_HW1) ? `RSC_SLOT_TS3 :
    (reg9_sleep_slot_q == `RSC_SLOT_CODE_HW2) ? `RSC_SLOT_TS1 :
    r9_mid_slot;                                             // [RULE1]
  // Hardware-enabled regulator enters sleep rather than switching off
  wire r9_is_disable = r9_code_mid & ~reg9_hw_assigned;     // [RULE2]
  wire sleep_strobe  = seq_slot_strobe & ~seq_powerup;
  wire up_strobe     = seq_slot_strobe & seq_powerup;
  wire r9_hit        = sleep_strobe & (seq_slot_num == r9_target);

  // Ninth regulator flags; a power-up strobe clears the sleep and disable flags
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg9_sleep_active_q <= 1'b0;
      reg9_disable_q      <= 1'b0;
      reg9_vcode_q        <= `RSC_RST_VCODE;
      reg9_lowpower_q     <= `RSC_RST_SLEEP_MODE;
      reg9_millivolts_q   <= `RSC_MV_BASE_LO;
    end
    else
    begin
      if (r9_hit)
      begin
        reg9_sleep_active_q <= ~r9_is_disable;              // [RULE1]
        reg9_disable_q      <= r9_is_disable;               // [RULE1]
      end
      else if (up_strobe)
      begin
        reg9_sleep_active_q <= 1'b0;
        reg9_disable_q      <= 1'b0;
      end
      reg9_vcode_q      <= reg9_sleep_voltage_code_q;
      reg9_lowpower_q   <= reg9_sleep_opmode_q;             // [RULE3]
      reg9_millivolts_q <= vcode_mv(reg9_sleep_voltage_code_q);
    end
  end

  // Tenth regulator hardware control request from the chosen inputs
  assign hw_active =
    ((reg10_hw_ctrl_source_q == `RSC_HWSRC_IN1) & hw1) |
    ((reg10_hw_ctrl_source_q == `RSC_HWSRC_IN2) & hw2) |
    ((reg10_hw_ctrl_source_q == `RSC_HWSRC_ANY) & (hw1 | hw2)); // [RULE7]

  wire r10_slot_seq = (reg10_on_slot_q >= `RSC_SLOT_FIRST) &&
                      (reg10_on_slot_q <= `RSC_SLOT_LAST);
  wire r10_on_hit   = up_strobe & r10_slot_seq &
                      (seq_slot_num == reg10_on_slot_q);    // [RULE11]
  wire r10_sleep_hit = sleep_strobe &
                       (seq_slot_num == `RSC_R10_SLEEP_SLOT); // [RULE14]

  // Sequencer-driven state of the tenth regulator
  always_comb
  begin
    r10_state_d = r10_state_q;
    case (r10_state_q)
      RSC_R10_OFF:
      begin
        if (r10_on_hit)
          r10_state_d = RSC_R10_ON;                          // [RULE11]
      end
      RSC_R10_ON:
      begin
        if (r10_sleep_hit)
          r10_state_d = RSC_R10_SLEEP;                       // [RULE14]
        else if (!r10_slot_seq)
          r10_state_d = RSC_R10_OFF;
      end
      RSC_R10_SLEEP:
      begin
        if (up_strobe)
          r10_state_d = RSC_R10_ON;                          // [RULE14]
        else if (!r10_slot_seq)
          r10_state_d = RSC_R10_OFF;
      end
      default:
        r10_state_d = RSC_R10_OFF;
    endcase
  end

  // Enable source: timeslot state or a hardware enable input
  wire r10_base_en =
    r10_slot_seq ? (r10_state_q != RSC_R10_OFF) :
    (reg10_on_slot_q == `RSC_SLOT_CODE_HW1) ? hw1 :
    (reg10_on_slot_q == `RSC_SLOT_CODE_HW2) ? hw2 : 1'b0;   // [RULE11]
  wire hw_mode_off = hw_active &
                     (reg10_hw_ctrl_opmode_q == `RSC_HWMODE_OFF); // [RULE9]
  wire r10_en_d = r10_base_en & ~hw_mode_off & ~fault_off_q;

  // Voltage and mode selection: hardware control, then sleep, then on
  wire [4:0] r10_vcode_d =
    hw_active ? (reg10_hw_ctrl_voltage_pick_q ?
                 reg10_sleep_voltage_code_q :
                 reg10_on_voltage_code_q) :                 // [RULE8]
    (r10_state_q == RSC_R10_SLEEP) ? reg10_sleep_voltage_code_q :
    reg10_on_voltage_code_q;                    // [RULE13] [RULE14]
  // Sleep mode of the tenth regulator is held at its low-power default
  wire r10_lp_d =
    hw_active ? ((reg10_hw_ctrl_opmode_q == `RSC_HWMODE_FOLLOW) ?
                 reg10_on_opmode_q : 1'b1) :                // [RULE9]
    (r10_state_q == RSC_R10_SLEEP) ? `RSC_RST_SLEEP_MODE :  // [RULE14]
    reg10_on_opmode_q;                                       // [RULE12]

  // Undervoltage response; the fault latch is set over any clear
  wire uv_rise   = uv & ~uv_prev_q;
  wire fault_set = uv_rise &
                   (reg10_fault_action_q == `RSC_FAULT_REG_OFF); // [RULE5]
  wire fault_clr = wr_r10o | r10_on_hit;
  assign fault_off_d = fault_set | (fault_off_q & ~fault_clr);

  // Tenth regulator state and pins
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r10_state_q        <= RSC_R10_OFF;
      fault_off_q        <= 1'b0;
      uv_prev_q          <= 1'b0;
      reg10_enable_q     <= 1'b0;
      reg10_vcode_q      <= `RSC_RST_VCODE;
      reg10_lowpower_q   <= `RSC_RST_ON_MODE;
      reg10_millivolts_q <= `RSC_MV_BASE_LO;
      reg10_discharge_q  <= 1'b1;
      reg10_switch_q     <= 1'b0;
      uv_irq_q           <= 1'b0;
      sys_reset_req_q    <= 1'b0;
    end
    else
    begin
      r10_state_q        <= r10_state_d;
      fault_off_q        <= fault_off_d;                    // [RULE5]
      uv_prev_q          <= uv;
      reg10_enable_q     <= r10_en_d;
      reg10_vcode_q      <= r10_vcode_d;
      reg10_lowpower_q   <= r10_lp_d;
      reg10_millivolts_q <= vcode_mv(r10_vcode_d);          // [RULE13]
      // Discharge only while off and not set to float
      reg10_discharge_q  <= ~r10_en_d & ~reg10_output_float_q; // [RULE10]
      reg10_switch_q     <= reg10_switch_select_q;          // [RULE10]
      // Every new undervoltage is reported, even when ignored
      uv_irq_q           <= uv_rise;                        // [RULE6]
      sys_reset_req_q    <= uv_rise &
        (reg10_fault_action_q == `RSC_FAULT_SYS_RESET);     // [RULE5]
    end
  end

endmodule : rsc_top
`default_nettype wire
